// File: shared/miru_pkg.sv
// Operation
// RQ1: conversion-done event sets its flag; that flag alone is an independent request.
// RQ2: converter vector taken only with global enable, converter enable and flag set.
// RQ3: no interrupt call starts while the return stack is full; request waits.
// RQ4: servicing converter interrupt clears its flag and the global enable.
// RQ5: each timer has period and compare-A flags, each with its own enable.
// RQ6: timer period or compare-A match sets the matching timer flag.
// RQ7: timer vector needs global, timer source and group enables all set.
// RQ8: grouped service clears group flag and global enable, keeps source flag.
// RQ9: end of data-memory write cycle sets write-done flag, a grouped source.
// RQ10: write-done flag survives service, cleared only by software; needs three enables.
// RQ11: low-supply report sets low-supply flag, a grouped source.
// RQ12: low-supply flag survives service until software clears it; group flag clears.
// RQ13: in sleep or idle, any flag rising wakes the device, enables ignored.
// RQ14: flag already high at sleep entry gives no wake-up.
// RQ15: a set flag holds regardless of enable until serviced or cleared.
// RQ16: interrupt entry pushes only the program counter.
// RQ17: interrupt return sets global enable; plain return leaves it cleared.
// RQ18: three group flags; only these clear automatically on grouped service.
// RQ19: group flag sets when a member flag is raised with its enable set.
// RQ20: low-supply request raised only after a settling delay from low-voltage bit.
// RQ21: simultaneous enabled requests serviced lowest vector first.
package miru_pkg;
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_FLAG = 12'h004;
   localparam logic [11:0] ADDR_ENAB = 12'h008;
   localparam logic [11:0] ADDR_STAT = 12'h00c;
   // flag and enable bit positions (same in both registers)
   localparam int B_CONV = 0;
   localparam int B_T0P = 1;
   localparam int B_T0A = 2;
   localparam int B_T1P = 3;
   localparam int B_T1A = 4;
   localparam int B_NVM = 5;
   localparam int B_LVS = 6;
   localparam int B_MF0 = 7;
   localparam int NSRC = 10;
   localparam int NGRP = 3;
   localparam int B_GIE = 0;
   localparam logic [9:0] FLAG_RST = 10'h000;
   localparam logic [9:0] ENAB_RST = 10'h000;
   // vectors, lowest first is highest priority
   localparam logic [3:0] VEC_CONV = 4'h1;
   localparam logic [3:0] VEC_MF0 = 4'h2;
   localparam logic [3:0] VEC_MF1 = 4'h3;
   localparam logic [3:0] VEC_MF2 = 4'h4;
   localparam logic [3:0] VEC_NONE = 4'h0;
   localparam int LVS_SETTLE_NS = 200;
   localparam int CLK_NS = 20;
   localparam logic [7:0] LVS_SETTLE_CYC =
      8'((LVS_SETTLE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
endpackage

// File: rtl/miru_irq_unit.sv
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module miru_irq_unit (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic conv_done, // pulse: conversion finished
   input wire logic [1:0] tmr_period_match, // pulse per timer
   input wire logic [1:0] tmr_cmp_a_match, // pulse per timer
   input wire logic nvm_write_end, // pulse: write cycle ended
   input wire logic low_voltage_output_bit, // async level from monitor
   input wire logic stack_full, // core return stack full
   input wire logic irq_ack, // core took the vector
   input wire logic ret_irq, // interrupt return executed
   input wire logic ret_plain, // plain return executed
   input wire logic sleep_mode, // core in sleep or idle
   output logic irq_req, // vector request to core
   output logic [3:0] irq_vector, // vector index
   output logic push_pc_only, // core pushes program counter only
   output logic wake_up // wake pulse
);
   logic [9:0] flag;
   logic [9:0] enab;
   logic gie;
   logic [1:0] lv_sync;
   logic [7:0] lv_cnt;
   logic lv_event;
   logic [9:0] src_set;
   logic [9:0] sw_clr;
   logic [9:0] sw_set;
   logic [9:0] svc_clr;
   logic [9:0] flag_prev;
   logic [3:0] next_vec;
   logic wr;
   logic rd;

   function automatic logic [3:0] pick(input logic [9:0] f,
                                       input logic [9:0] e);
      // fixed priority: converter, then groups 0..2
      if (f[miru_pkg::B_CONV] && e[miru_pkg::B_CONV]) begin
         return miru_pkg::VEC_CONV;
      end else if (f[7] && e[7]) begin
         return miru_pkg::VEC_MF0;
      end else if (f[8] && e[8]) begin
         return miru_pkg::VEC_MF1;
      end else if (f[9] && e[9]) begin
         return miru_pkg::VEC_MF2;
      end else begin
         return miru_pkg::VEC_NONE;
      end
   endfunction

   ////////////////////////////////////////////////////////////////
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= miru_pkg::PRDATA_RST;
      end else begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         if (rd) begin
            if (paddr == miru_pkg::ADDR_CTRL) begin
               prdata <= {31'h0000_0000, gie};
            end else if (paddr == miru_pkg::ADDR_FLAG) begin
               prdata <= {22'h00_0000, flag};
            end else if (paddr == miru_pkg::ADDR_ENAB) begin
               prdata <= {22'h00_0000, enab};
            end else if (paddr == miru_pkg::ADDR_STAT) begin
               prdata <= {27'h000_0000, irq_req, irq_vector};
            end else begin
               prdata <= miru_pkg::PRDATA_RST;
               pslverr <= 1'b1;
            end
         end
      end
   end

   // writes take effect at the access edge where pready is high
   assign sw_set = (wr && pready && paddr == miru_pkg::ADDR_FLAG) ?
                   pwdata[9:0] : 10'h000;
   assign sw_clr = (wr && pready && paddr == miru_pkg::ADDR_FLAG) ?
                   ~pwdata[9:0] : 10'h000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enab <= miru_pkg::ENAB_RST;
      end else if (wr && pready && paddr == miru_pkg::ADDR_ENAB) begin
         enab <= pwdata[9:0];
      end
   end

   ////////////////////////////////////////////////////////////////
   // low-voltage level is asynchronous; settle counter gates the flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_sync <= 2'b00;
         lv_cnt <= 8'h00;
      end else begin
         lv_sync <= {lv_sync[0], low_voltage_output_bit};
         if (!lv_sync[1]) begin
            lv_cnt <= 8'h00;
         end else if (lv_cnt != miru_pkg::LVS_SETTLE_CYC) begin
            lv_cnt <= lv_cnt + 8'h01; // RQ20
         end
      end
   end
   assign lv_event = lv_sync[1] && (lv_cnt == miru_pkg::LVS_SETTLE_CYC - 8'h01);

   always_comb begin
      src_set = 10'h000;
      src_set[miru_pkg::B_CONV] = conv_done; // RQ1
      src_set[miru_pkg::B_T0P] = tmr_period_match[0]; // RQ6
      src_set[miru_pkg::B_T0A] = tmr_cmp_a_match[0];
      src_set[miru_pkg::B_T1P] = tmr_period_match[1];
      src_set[miru_pkg::B_T1A] = tmr_cmp_a_match[1]; // RQ5
      src_set[miru_pkg::B_NVM] = nvm_write_end; // RQ9
      src_set[miru_pkg::B_LVS] = lv_event; // RQ11
      // group 0: timer 0, group 1: timer 1, group 2: nvm and low supply
      src_set[7] = |(flag[2:1] & enab[2:1]); // RQ19
      src_set[8] = |(flag[4:3] & enab[4:3]);
      src_set[9] = |(flag[6:5] & enab[6:5]);
   end

   // service clears converter or the one group flag only
   always_comb begin
      svc_clr = 10'h000;
      if (irq_ack && irq_req) begin
         if (irq_vector == miru_pkg::VEC_CONV) begin
            svc_clr[miru_pkg::B_CONV] = 1'b1; // RQ4
         end else if (irq_vector == miru_pkg::VEC_MF0) begin
            svc_clr[7] = 1'b1; // RQ8
         end else if (irq_vector == miru_pkg::VEC_MF1) begin
            svc_clr[8] = 1'b1; // RQ18
         end else if (irq_vector == miru_pkg::VEC_MF2) begin
            svc_clr[9] = 1'b1; // RQ10 RQ12
         end
      end
   end

   // group flags are level-derived, so a clear only sticks after
   // software clears the source flag or its enable; set wins over a clear, except that service clear beats a group's source set
   genvar g;
   generate
      for (g = 0; g < miru_pkg::NSRC; g = g + 1) begin : g_flag
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flag[g] <= 1'b0;
            end else if ((src_set[g] && !(g >= 7 && svc_clr[g])) ||
                         sw_set[g]) begin
               flag[g] <= 1'b1;
            end else if (sw_clr[g] || svc_clr[g]) begin
               flag[g] <= 1'b0; // RQ15
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie <= 1'b0;
      end else if (irq_ack && irq_req) begin
         gie <= 1'b0; // RQ4
      end else if (ret_irq) begin
         gie <= 1'b1; // RQ17
      end else if (wr && pready && paddr == miru_pkg::ADDR_CTRL) begin
         gie <= pwdata[miru_pkg::B_GIE];
      end
   end

   ////////////////////////////////////////////////////////////////
   assign next_vec = pick(flag, {enab[9:7], 6'h00, enab[0]}); // RQ21

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 1'b0;
         irq_vector <= miru_pkg::VEC_NONE;
         push_pc_only <= 1'b0;
      end else begin
         irq_req <= gie && !stack_full && !(irq_ack && irq_req) &&
                    (next_vec != miru_pkg::VEC_NONE); // RQ2 RQ3 RQ7
         irq_vector <= next_vec;
         push_pc_only <= irq_ack && irq_req; // RQ16
      end
   end

   ////////////////////////////////////////////////////////////////
   // previous flags sampled every cycle, so a flag high at entry
   // shows no rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_prev <= miru_pkg::FLAG_RST;
         wake_up <= 1'b0;
      end else begin
         flag_prev <= flag;
         wake_up <= sleep_mode && |(flag & ~flag_prev); // RQ13 RQ14
      end
   end

   ////////////////////////////////////////////////////////////////
   // all checks live in the one clock domain and share its reset
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // an accepted vector: the take, then the stacked entry
   sequence s_take;
      irq_ack && irq_req;
   endsequence

   sequence s_entry;
      push_pc_only && !irq_req && !gie;
   endsequence

   a_req_needs_gie: assert property ( // RQ3
      irq_req |-> $past(gie) && !$past(stack_full))
      else $error("request without global enable or with full stack");

   a_ack_clears_gie: assert property ( // RQ4
      irq_ack && irq_req |=> !gie)
      else $error("global enable not cleared on service");

   a_conv_clear: assert property ( // RQ4
      irq_ack && irq_req && irq_vector == miru_pkg::VEC_CONV && !conv_done
      && !sw_set[0] |=> !flag[0])
      else $error("converter flag not cleared on service");

   a_src_kept: assert property ( // RQ10
      irq_ack && irq_req && flag[5] && !sw_clr[5] |=> flag[5])
      else $error("write-done flag lost on service");

   a_lv_kept: assert property ( // RQ12
      flag[6] && !sw_clr[6] |=> flag[6])
      else $error("low-supply flag lost without software");

   a_conv_sets: assert property ( // RQ1
      conv_done |=> flag[0])
      else $error("converter flag not set");

   a_return_from_irq_instr_gie: assert property ( // RQ17
      ret_irq && !(irq_ack && irq_req) |=> gie)
      else $error("interrupt return did not set global enable");

   a_ret_plain: assert property ( // RQ17
      ret_plain && !ret_irq && !gie && !wr |=> !gie)
      else $error("plain return changed global enable");

   a_wake_edge: assert property ( // RQ13
      wake_up |-> $past(sleep_mode) && ($past(flag) & ~$past(flag_prev)) != 0)
      else $error("wake-up without a rising flag");

   a_lv_delay: assert property ( // RQ20
      $rose(flag[6]) && !$past(sw_set[6]) |-> $past(lv_sync[1], 2))
      else $error("low-supply flag set before settling");

   a_entry_steps: assert property ( // RQ16
      s_take |=> s_entry)
      else $error("interrupt entry steps out of order");

   a_push_cause: assert property ( // RQ16
      push_pc_only |-> $past(irq_ack && irq_req))
      else $error("counter push without an accepted vector");

   a_req_has_vec: assert property ( // RQ2
      irq_req |-> irq_vector != miru_pkg::VEC_NONE)
      else $error("request without a vector");

   a_conv_enables: assert property ( // RQ2
      irq_req && irq_vector == miru_pkg::VEC_CONV
      |-> $past(flag[0] && enab[0] && gie))
      else $error("converter vector without its enables");

   a_mf0_enables: assert property ( // RQ7
      irq_req && irq_vector == miru_pkg::VEC_MF0
      |-> $past(flag[7] && enab[7] && gie))
      else $error("group 0 vector without its enables");

   a_mf1_enables: assert property ( // RQ7
      irq_req && irq_vector == miru_pkg::VEC_MF1
      |-> $past(flag[8] && enab[8] && gie))
      else $error("group 1 vector without its enables");

   a_mf2_enables: assert property ( // RQ10
      irq_req && irq_vector == miru_pkg::VEC_MF2
      |-> $past(flag[9] && enab[9] && gie))
      else $error("group 2 vector without its enables");

   a_conv_first: assert property ( // RQ21
      irq_req && $past(flag[0] && enab[0])
      |-> irq_vector == miru_pkg::VEC_CONV)
      else $error("converter not served first");

   a_mf0_before: assert property ( // RQ21
      irq_req && $past(flag[7] && enab[7] && !(flag[0] && enab[0]))
      |-> irq_vector == miru_pkg::VEC_MF0)
      else $error("group 0 not served before later groups");

   a_mf1_before: assert property ( // RQ21
      irq_req && $past(flag[8] && enab[8] && !(flag[0] && enab[0])
      && !(flag[7] && enab[7]))
      |-> irq_vector == miru_pkg::VEC_MF1)
      else $error("group 1 not served before group 2");

   a_full_blocks: assert property ( // RQ3
      stack_full |=> !irq_req)
      else $error("request raised while the stack is full");

   a_gie_blocks: assert property ( // RQ4
      !gie |=> !irq_req)
      else $error("request raised with global enable clear");

   a_tmr_sets: assert property ( // RQ6
      tmr_period_match[0] |=> flag[1])
      else $error("timer period flag not set");

   a_cmpa_sets: assert property ( // RQ5
      tmr_cmp_a_match[1] |=> flag[4])
      else $error("timer compare-a flag not set");

   a_nvm_sets: assert property ( // RQ9
      nvm_write_end |=> flag[5])
      else $error("write-done flag not set");

   a_lv_sets: assert property ( // RQ11
      lv_event |=> flag[6])
      else $error("low-supply flag not set");

   a_lv_settle: assert property ( // RQ20
      $rose(lv_sync[1]) |-> !lv_event [*8])
      else $error("low-supply event before settling");

   a_grp0_sets: assert property ( // RQ19
      flag[1] && enab[1] && !svc_clr[7] |=> flag[7])
      else $error("group 0 flag not set by enabled member");

   a_grp2_sets: assert property ( // RQ19
      flag[6] && enab[6] && !svc_clr[9] |=> flag[9])
      else $error("group 2 flag not set by enabled member");

   a_tmr_kept: assert property ( // RQ8
      irq_ack && irq_req && flag[1] && !sw_clr[1] |=> flag[1])
      else $error("timer flag lost on group service");

   a_grp_clear: assert property ( // RQ18
      irq_ack && irq_req && irq_vector == miru_pkg::VEC_MF1
      && !src_set[8] && !sw_set[8] |=> !flag[8])
      else $error("group 1 flag not cleared on service");

   a_wake_awake: assert property ( // RQ13
      !sleep_mode |=> !wake_up)
      else $error("wake-up while running");

   a_no_rise: assert property ( // RQ14
      flag == flag_prev |=> !wake_up)
      else $error("wake-up from a flag that did not rise");

   a_flag_holds: assert property ( // RQ15
      flag[3] && !sw_clr[3] |=> flag[3])
      else $error("timer flag dropped without a clear");

   // bus handshake is fixed at zero wait states
   a_ready_once: assert property (
      psel && !penable |=> pready)
      else $error("ready missing in access phase");

   a_ready_cause: assert property (
      pready |-> $past(psel && !penable))
      else $error("ready without a setup phase");

   a_err_ready: assert property (
      pslverr |-> pready)
      else $error("error response without ready");
endmodule
`default_nettype wire

// File: tb/miru_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module miru_core_model #(
   parameter int DEPTH = 1 // return stack levels
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, low
   input wire logic irq_req, // vector request
   input wire logic push_pc_only, // pc pushed
   input wire logic ret_any, // a return popped the stack
   input wire logic [3:0] ack_wait, // cycles before the vector is taken
   output logic stack_full, // return stack full
   output var logic irq_ack // vector taken
);
   int depth;
   logic [3:0] wait_cnt;
   assign stack_full = (depth >= DEPTH);
   // ack lasts one cycle, the request drops at that same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt <= 4'h0;
         irq_ack <= 1'b0;
      end else begin
         irq_ack <= irq_req && !irq_ack && (wait_cnt >= ack_wait);
         wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
      end
   end
   // only the program counter is stacked, nothing else is kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         depth <= 0;
      end else if (push_pc_only && !ret_any) begin
         depth <= depth + 1;
      end else if (ret_any && !push_pc_only && depth > 0) begin
         depth <= depth - 1;
      end
   end
endmodule
`default_nettype wire

// File: tb/tb_mcu_interrupt_request_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_interrupt_request_unit;
   localparam logic [11:0] CT = miru_pkg::ADDR_CTRL;
   localparam logic [11:0] FL = miru_pkg::ADDR_FLAG;
   localparam logic [11:0] EN = miru_pkg::ADDR_ENAB;
   localparam logic [31:0] Z = 32'h0000_0000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [7:0] evt;
   logic lvb, sleep_mode, irq_req, push_pc_only, wake_up, full, ack, seen;
   logic [3:0] irq_vector, ack_wait;
   int bad_count = 0;
   int check_count = 0;
   int n;
   miru_irq_unit i_miru_irq_unit (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .conv_done(evt[0]), .tmr_period_match({evt[3], evt[1]}),
      .tmr_cmp_a_match({evt[4], evt[2]}), .nvm_write_end(evt[5]),
      .low_voltage_output_bit(lvb), .stack_full(full), .irq_ack(ack),
      .ret_irq(evt[6]), .ret_plain(evt[7]), .sleep_mode(sleep_mode),
      .irq_req(irq_req), .irq_vector(irq_vector),
      .push_pc_only(push_pc_only), .wake_up(wake_up));
   miru_core_model #(.DEPTH(1)) i_miru_core_model (.pclk(pclk),
      .presetn(presetn), .irq_req(irq_req), .push_pc_only(push_pc_only),
      .ret_any(evt[6] | evt[7]), .ack_wait(ack_wait), .stack_full(full),
      .irq_ack(ack));
   ////////////////////////////////////////////////////////////
   function automatic logic [31:0] b(input int i);
      return 32'h0000_0001 << i;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // pready, prdata and pslverr are taken at the completing rising edge
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         bad_count++;
         complete_run();
      end
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [11:0] a,
         input logic [31:0] m, e);
      apb(1'b0, a, Z);
      chk(nm, e, r & m);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic pulse(input logic [31:0] m);
      @(posedge pclk);
      evt <= m[7:0];
      @(posedge pclk);
      evt <= 8'h00;
   endtask
   task automatic await(input int s, input int lim);
      n = 0;
      seen = 1'b0;
      while (!seen && n < lim) begin
         @(negedge pclk);
         n++;
         seen = ((s == 0) ? irq_req : (s == 1) ? push_pc_only : wake_up)
            === 1'b1;
      end
   endtask
   task automatic serve(input logic [3:0] v);
      await(0, 30);
      chk("vector", {28'h0, v}, {28'h0, irq_vector});
      if (!seen) begin
         bad_count++;
         complete_run();
      end
      await(1, 30);
      chk("pc push", b(0), {31'h0, seen});
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd("ctrl reset", CT, 32'hffff_ffff, Z);
      rd("flag reset", FL, 32'hffff_ffff, Z);
      rd("enab reset", EN, 32'hffff_ffff, Z);
      rd("unmapped", 12'h010, Z, Z);
      chk("slverr", b(0), {31'h0, err});
      $display("regs done");
   endtask
   task automatic t_sources();
      for (int i = 1; i < 6; i++) begin
         pulse(b(i));
         rd("source flag", FL, b(i), b(i));
      end
      rd("no group", FL, 32'h0000_0380, Z);
      wr(FL, Z);
      $display("sources done");
   endtask
   task automatic t_conv();
      ack_wait <= 4'h8;
      wr(EN, b(0));
      pulse(b(0));
      rd("conv flag", FL, b(0), b(0));
      wr(CT, b(0));
      serve(miru_pkg::VEC_CONV);
      rd("conv cleared", FL, b(0), Z);
      rd("gie cleared", CT, b(0), Z);
      wr(CT, b(0));
      pulse(b(0));
      await(0, 8);
      chk("held while full", Z, {31'h0, seen});
      pulse(b(6));
      serve(miru_pkg::VEC_CONV);
      pulse(b(7));
      rd("plain return", CT, b(0), Z);
      $display("conv done");
   endtask
   task automatic t_group();
      ack_wait <= 4'h0;
      wr(EN, b(1));
      wr(CT, b(0));
      pulse(b(1));
      await(0, 8);
      chk("no group enable", Z, {31'h0, seen});
      rd("group flag", FL, b(1) | b(7), b(1) | b(7));
      wr(EN, b(1) | b(7));
      serve(miru_pkg::VEC_MF0);
      rd("source kept", FL, b(1), b(1));
      rd("gie after group", CT, b(0), Z);
      wr(EN, Z);
      wr(FL, Z);
      pulse(b(6));
      rd("irq return", CT, b(0), b(0));
      $display("group done");
   endtask
   task automatic t_prio();
      wr(CT, Z);
      wr(EN, b(0) | b(3) | b(5) | 32'h0000_0380);
      pulse(b(0) | b(3) | b(5));
      wr(CT, b(0));
      serve(miru_pkg::VEC_CONV);
      pulse(b(6));
      serve(miru_pkg::VEC_MF1);
      wr(EN, b(5) | b(9));
      pulse(b(6));
      serve(miru_pkg::VEC_MF2);
      rd("write done kept", FL, b(5), b(5));
      wr(EN, Z);
      wr(FL, Z);
      pulse(b(7));
      $display("prio done");
   endtask
   task automatic t_wake();
      sleep_mode <= 1'b1;
      pulse(b(5));
      await(2, 8);
      chk("wake on rise", b(0), {31'h0, seen});
      pulse(b(5));
      await(2, 8);
      chk("no wake when high", Z, {31'h0, seen});
      @(posedge pclk);
      lvb <= 1'b1;
      await(2, 40);
      chk("settle", b(0), {31'h0, seen && n >= 10 && n <= 16});
      @(posedge pclk);
      sleep_mode <= 1'b0;
      lvb <= 1'b0;
      wr(EN, b(6) | b(9));
      wr(CT, b(0));
      serve(miru_pkg::VEC_MF2);
      rd("low supply kept", FL, b(6), b(6));
      wr(EN, Z);
      wr(FL, Z);
      pulse(b(7));
      $display("wake done");
   endtask
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   initial begin
      {psel, penable, pwrite, lvb, sleep_mode, presetn} = 6'h00;
      paddr = 12'h000;
      pwdata = Z;
      evt = 8'h00;
      ack_wait = 4'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_sources();
      t_conv();
      t_group();
      t_prio();
      t_wake();
      complete_run();
   end
endmodule
`default_nettype wire
